/* File: logic/fsb_dev.sv */
// Bridge end: fieldbus slave images to serial byte stream
//
// Function
// - Master polls every interval, resending unchanged data
// - Master puts a marker byte first
// - Changed first byte means new; send immediately
// - Same first byte: send nothing serially
// - Images limited to 128 bytes each
// - Input image starts with three status bytes
// - State byte: 0 idle, 1 send, 2 copy
// - Rx data fills input bytes 4 to 128
// - Length byte counts bytes moved from rx buffer
// - Short input image truncates packet for master
// - Counter byte increments once per copied packet
// - Input payload holds until next packet copied
// - Master checks counter to spot new data
// - Status header prefixes each packet for master
// - Five setting bytes, payload from byte 6
// - Output length resets to zero, resent always
// - Always a slave on the fieldbus
// - Local master: send request, capture response
// - Listener: capture every serial message
// - Control bits clear diagnostics and counter
// - Send min of length byte and payload
// - Rx gap beyond timeout ends message
// - Fixed mode waits for full byte count
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
module fsb_dev #(
  parameter int MS_CYC   = fsb_pkg::MS_CYC_DEF,   // Cycles per millisecond
  parameter int CHAR_CYC = fsb_pkg::CHAR_CYC_DEF  // Cycles per character
) (
  input  wire logic       CLK_SYS_I,    // System clock
  input  wire logic       RST_I,        // Synchronous reset
  fsb_if.dev              FB,           // Image link, slave role only
  output logic [7:0]      TX_DATA_O,    // Serial transmit byte
  output logic            TX_VALID_O,   // Transmit byte valid
  input  wire logic       TX_READY_I,   // Serial port takes byte
  input  wire logic [7:0] RX_DATA_I,    // Serial receive byte
  input  wire logic       RX_VALID_I,   // Receive byte strobe
  input  wire logic       LISTEN_I,     // 1 passive listener, 0 local master
  input  wire logic       FIX_EN_I,     // Fixed receive length mode
  input  wire logic       TMO_10MS_I,   // Timeout unit 10 ms, else 1 ms
  output logic            DIAG_CLR_O    // Diagnostic clear pulse
);

  ////////////////////////////////////////////////////////////////////////
  // Storage; this end only answers reads and never polls
  logic [7:0] out_mem [fsb_pkg::IMG_MAX];     // Output image copy
  logic [7:0] in_mem  [fsb_pkg::IMG_MAX];     // Input image payload part
  logic [7:0] rx_mem  [fsb_pkg::IN_PAY_MAX];  // Serial receive buffer

  fsb_pkg::fsb_dev_st_t st_r;  // Transfer state

  // Output image intake
  logic [7:0] ob_cnt_r;    // Bytes taken in current image
  logic       skip_r;      // Image arrived while sending
  logic       done_r;      // Image complete, settle one cycle
  logic [7:0] img_len_r;   // Size of last complete image
  logic [7:0] prev_cmd_r;  // Marker of last accepted command
  logic       pend_r;      // New command waiting for send
  // Latched settings
  logic [7:0] len_r;       // Output payload length
  logic [7:0] tmo_r;       // Receive timeout
  logic [7:0] fix_r;       // Fixed receive length
  // Transmit
  logic [6:0] tx_idx_r;    // Payload byte being sent
  logic [7:0] tx_len_r;    // Bytes to send
  logic       await_r;     // Local master expects a reply
  // Receive and status
  logic [6:0] rx_cnt_r;    // Bytes buffered
  logic [6:0] cp_idx_r;    // Copy position
  logic [7:0] st_len_r;    // Status length byte
  logic [7:0] st_cnt_r;    // Status counter byte
  logic       cnt_clr;     // Counter clear request
  // Gap timing
  logic [23:0] ms_cnt_r;   // Millisecond divider
  logic [3:0]  dec_cnt_r;  // Tens divider
  logic        unit_tick;  // One timeout unit elapsed
  logic [7:0]  gap_r;      // Unit ticks since last rx byte
  logic [23:0] chr_cnt_r;  // Cycles since last rx byte
  logic        rx_en;      // Receive window open
  logic        msg_end;    // Buffered message complete
  logic        tx_start;   // Begin serial send
  logic [7:0]  pay_room;   // Payload bytes the image holds

  ////////////////////////////////////////////////////////////////////////
  // Take output image bytes; marker compared one cycle after last byte
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ob_cnt_r  <= 8'h00;
      skip_r    <= 1'b0;
      done_r    <= 1'b0;
      img_len_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (FB.ob_valid) begin
        // Payload must not change under an active send
        if (ob_cnt_r == 8'h00) begin
          skip_r <= (st_r == fsb_pkg::DS_SEND);
        end
        // Bytes past 128 are ignored
        if (ob_cnt_r < 8'(fsb_pkg::IMG_MAX)) begin
          ob_cnt_r <= ob_cnt_r + 8'h01;
        end
        if (FB.ob_last) begin
          ob_cnt_r  <= 8'h00;
          img_len_r <= fsb_pkg::min8(ob_cnt_r + 8'h01, 8'(fsb_pkg::IMG_MAX));
          done_r    <= 1'b1;
        end
      end
    end
  end

  // Image memory write, blocked while sending
  always_ff @(posedge CLK_SYS_I) begin
    if (FB.ob_valid && ob_cnt_r < 8'(fsb_pkg::IMG_MAX)
        && !(ob_cnt_r == 8'h00 ? st_r == fsb_pkg::DS_SEND : skip_r)) begin
      out_mem[ob_cnt_r[6:0]] <= FB.ob_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings and marker check; images resent every poll are dropped
  // when the marker repeats, so a skipped image returns next poll
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      prev_cmd_r <= fsb_pkg::CMD_RST;
      pend_r     <= 1'b0;
      len_r      <= fsb_pkg::LEN_RST;
      tmo_r      <= 8'h00;
      fix_r      <= 8'h00;
      DIAG_CLR_O <= 1'b0;
    end else begin
      DIAG_CLR_O <= 1'b0;
      if (tx_start) begin
        pend_r <= 1'b0;
      end
      if (done_r && !skip_r && img_len_r > 8'(fsb_pkg::OB_FIX)) begin
        // Receive behaviour follows every telegram not skipped, new marker or not
        tmo_r <= out_mem[fsb_pkg::OB_TMO];
        fix_r <= out_mem[fsb_pkg::OB_FIX];
        if (out_mem[fsb_pkg::OB_CMD] != prev_cmd_r) begin
          prev_cmd_r <= out_mem[fsb_pkg::OB_CMD];
          pend_r     <= 1'b1;
          len_r      <= out_mem[fsb_pkg::OB_LEN];
          DIAG_CLR_O <= out_mem[fsb_pkg::OB_CTRL][fsb_pkg::DIAG_CLR_POS];
        end
        // Same marker: nothing forwarded
      end
    end
  end

  // Counter clear rides on a new command
  assign cnt_clr = done_r && !skip_r && img_len_r > 8'(fsb_pkg::OB_FIX)
                   && out_mem[fsb_pkg::OB_CMD] != prev_cmd_r
                   && out_mem[fsb_pkg::OB_CTRL][fsb_pkg::CNT_CLR_POS];

  ////////////////////////////////////////////////////////////////////////
  // Send length: length byte, capped by payload in the image
  assign pay_room = img_len_r - 8'(fsb_pkg::OUT_HDR);
  assign tx_start = (st_r == fsb_pkg::DS_IDLE) && pend_r;

  // Main state: send has priority over copy
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_r       <= fsb_pkg::DS_IDLE;
      TX_VALID_O <= 1'b0;
      TX_DATA_O  <= 8'h00;
      tx_idx_r   <= 7'h00;
      tx_len_r   <= 8'h00;
      await_r    <= 1'b0;
      cp_idx_r   <= 7'h00;
    end else begin
      case (st_r)
        fsb_pkg::DS_IDLE: begin
          if (tx_start) begin
            tx_len_r <= fsb_pkg::min8(len_r, pay_room);
            if (fsb_pkg::min8(len_r, pay_room) != 8'h00) begin
              st_r       <= fsb_pkg::DS_SEND;
              TX_VALID_O <= 1'b1;
              TX_DATA_O  <= out_mem[fsb_pkg::OUT_HDR];
              tx_idx_r   <= 7'h00;
            end
          end else if (msg_end) begin
            st_r     <= fsb_pkg::DS_COPY;
            cp_idx_r <= 7'h00;
          end
        end
        fsb_pkg::DS_SEND: begin
          if (TX_READY_I) begin
            if ({1'b0, tx_idx_r} == tx_len_r - 8'h01) begin
              TX_VALID_O <= 1'b0;
              st_r       <= fsb_pkg::DS_IDLE;
              await_r    <= 1'b1;
            end else begin
              tx_idx_r  <= tx_idx_r + 7'h01;
              TX_DATA_O <= out_mem[7'(fsb_pkg::OUT_HDR) + tx_idx_r + 7'h01];
            end
          end
        end
        fsb_pkg::DS_COPY: begin
          // One byte per cycle into bytes 4 onward
          if (cp_idx_r == rx_cnt_r - 7'h01) begin
            st_r    <= fsb_pkg::DS_IDLE;
            await_r <= 1'b0;
          end else begin
            cp_idx_r <= cp_idx_r + 7'h01;
          end
        end
        default: begin
          st_r <= fsb_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // Copy path into the input image
  always_ff @(posedge CLK_SYS_I) begin
    if (st_r == fsb_pkg::DS_COPY) begin
      in_mem[7'(fsb_pkg::IN_HDR) + cp_idx_r] <= rx_mem[cp_idx_r];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status length and counter change when a packet lands; a clear request also zeroes the counter
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_len_r <= 8'h00;
      st_cnt_r <= 8'h00;
    end else begin
      if (st_r == fsb_pkg::DS_COPY && cp_idx_r == rx_cnt_r - 7'h01) begin
        st_len_r <= {1'b0, rx_cnt_r};
        // Clear and increment together leave one
        st_cnt_r <= cnt_clr ? 8'h01 : st_cnt_r + 8'h01;
      end else if (cnt_clr) begin
        st_cnt_r <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive: a listener always hears, a local master only after a request
  assign rx_en = LISTEN_I || await_r;

  // Buffer bytes; bytes arriving during a copy are lost, a short limit
  // traded for a single buffer
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rx_cnt_r <= 7'h00;
    end else if (st_r == fsb_pkg::DS_COPY && cp_idx_r == rx_cnt_r - 7'h01) begin
      rx_cnt_r <= 7'h00;
    end else if (RX_VALID_I && rx_en && st_r != fsb_pkg::DS_COPY
                 && rx_cnt_r < 7'(fsb_pkg::IN_PAY_MAX)) begin
      rx_cnt_r <= rx_cnt_r + 7'h01;
    end
  end

  // Rx buffer write
  always_ff @(posedge CLK_SYS_I) begin
    if (RX_VALID_I && rx_en && st_r != fsb_pkg::DS_COPY
        && rx_cnt_r < 7'(fsb_pkg::IN_PAY_MAX)) begin
      rx_mem[rx_cnt_r] <= RX_DATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timeout unit divider, free running
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ms_cnt_r  <= 24'h000000;
      dec_cnt_r <= 4'h0;
    end else if (ms_cnt_r == 24'(MS_CYC - 1)) begin
      ms_cnt_r  <= 24'h000000;
      dec_cnt_r <= (dec_cnt_r == 4'(fsb_pkg::TMO_UNIT_X10 - 1)) ? 4'h0 : dec_cnt_r + 4'h1;
    end else begin
      ms_cnt_r <= ms_cnt_r + 24'h000001;
    end
  end

  assign unit_tick = (ms_cnt_r == 24'(MS_CYC - 1))
                     && (!TMO_10MS_I || dec_cnt_r == 4'(fsb_pkg::TMO_UNIT_X10 - 1));

  // Silence timers restart on every received byte
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || RX_VALID_I) begin
      gap_r     <= 8'h00;
      chr_cnt_r <= 24'h000000;
    end else begin
      if (unit_tick && gap_r != 8'hff) begin
        gap_r <= gap_r + 8'h01;
      end
      if (chr_cnt_r != 24'hffffff) begin
        chr_cnt_r <= chr_cnt_r + 24'h000001;
      end
    end
  end

  // End of message; first unit may be partial, so gap is tmo to tmo+1
  assign msg_end = (rx_cnt_r != 7'h00) && (FIX_EN_I
                   ? (fix_r != 8'h00 && {1'b0, rx_cnt_r} >= fix_r)
                   : (tmo_r == 8'h00 ? chr_cnt_r >= 24'(CHAR_CYC)
                                     : gap_r > tmo_r));

  ////////////////////////////////////////////////////////////////////////
  // Input image read port; header ahead of payload
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      FB.ib_valid <= 1'b0;
      FB.ib_data  <= 8'h00;
    end else begin
      FB.ib_valid <= FB.ib_rd;
      if (FB.ib_rd) begin
        case (FB.ib_idx)
          7'(fsb_pkg::IB_STATE): begin
            case (st_r)
              fsb_pkg::DS_SEND: FB.ib_data <= fsb_pkg::XS_SEND;
              fsb_pkg::DS_COPY: FB.ib_data <= fsb_pkg::XS_COPY;
              default:          FB.ib_data <= fsb_pkg::XS_IDLE;
            endcase
          end
          7'(fsb_pkg::IB_LEN): FB.ib_data <= st_len_r;
          7'(fsb_pkg::IB_CNT): FB.ib_data <= st_cnt_r;
          // Payload stays put until the next copy
          default: FB.ib_data <= in_mem[FB.ib_idx];
        endcase
      end
    end
  end

endmodule

/* File: logic/fsb_host.sv */
// Fieldbus master end: APB-programmed cyclic image poller
`timescale 1ns/1ns
module fsb_host #(
  parameter int POLL_CYC = fsb_pkg::POLL_CYC_DEF  // Cycles between polls
) (
  input  wire logic        CLK_SYS_I,  // System clock
  input  wire logic        RST_I,      // Synchronous reset
  fsb_if.host              FB,         // Image link, master role
  input  wire logic        PSEL_I,     // APB select
  input  wire logic        PENABLE_I,  // APB access phase
  input  wire logic        PWRITE_I,   // APB direction
  input  wire logic [11:0] PADDR_I,    // APB byte address
  input  wire logic [31:0] PWDATA_I,   // APB write data
  output logic [31:0]      PRDATA_O,   // APB read data
  output logic             PREADY_O,   // APB ready, one wait state
  output logic             PSLVERR_O   // Unmapped address, or write to status or input image
);

  logic [7:0]  out_mem [fsb_pkg::IMG_MAX];  // Output image to send
  logic [7:0]  in_mem  [fsb_pkg::IMG_MAX];  // Last input image read
  logic        run_r;        // Polling enabled
  logic [7:0]  olen_r;       // Output image size
  logic [7:0]  ilen_r;       // Input image size
  logic [15:0] cyc_cnt_r;    // Completed polls
  logic [23:0] tmr_r;        // Poll interval timer
  logic [7:0]  idx_r;        // Byte position in image
  logic [6:0]  cap_idx_r;    // Position of pending answer
  fsb_pkg::fsb_host_st_t st_r;
  logic        acc;          // APB access this cycle
  logic [6:0]  widx;         // Word index within image window
  logic        hit_out;      // Output window
  logic        hit_in;       // Input window

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign acc     = PSEL_I && PENABLE_I && !PREADY_O;
  assign widx    = {2'b00, PADDR_I[6:2]};
  assign hit_out = PADDR_I[11:7] == fsb_pkg::RA_OUTIMG[11:7];
  assign hit_in  = PADDR_I[11:7] == fsb_pkg::RA_INIMG[11:7];

  // APB answer one cycle into the access phase
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      run_r     <= 1'b0;
      olen_r    <= 8'h00;
      ilen_r    <= 8'h00;
    end else begin
      PREADY_O  <= acc;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
      if (acc) begin
        if (PADDR_I == fsb_pkg::RA_CTRL) begin
          if (PWRITE_I) begin
            run_r  <= PWDATA_I[fsb_pkg::CTRL_RUN_POS];
            // Sizes capped at 128 bytes
            olen_r <= fsb_pkg::min8(PWDATA_I[fsb_pkg::CTRL_OLEN_LSB +: 8], 8'h80);
            ilen_r <= fsb_pkg::min8(PWDATA_I[fsb_pkg::CTRL_ILEN_LSB +: 8], 8'h80);
          end
          PRDATA_O <= {8'h00, ilen_r, olen_r, 7'h00, run_r};
        end else if (PADDR_I == fsb_pkg::RA_STAT) begin
          PRDATA_O <= {15'h0000, st_r != fsb_pkg::HS_WAIT, cyc_cnt_r};
          PSLVERR_O <= PWRITE_I;
        end else if (hit_out) begin
          PRDATA_O <= {out_mem[{widx[4:0], 2'd3}], out_mem[{widx[4:0], 2'd2}],
                       out_mem[{widx[4:0], 2'd1}], out_mem[{widx[4:0], 2'd0}]};
        end else if (hit_in) begin
          PRDATA_O <= {in_mem[{widx[4:0], 2'd3}], in_mem[{widx[4:0], 2'd2}],
                       in_mem[{widx[4:0], 2'd1}], in_mem[{widx[4:0], 2'd0}]};
          PSLVERR_O <= PWRITE_I;
        end else begin
          PSLVERR_O <= 1'b1;
        end
      end
    end
  end

  // Output image words, little endian bytes
  always_ff @(posedge CLK_SYS_I) begin
    if (acc && PWRITE_I && hit_out) begin
      for (int b = 0; b < 4; b++) begin
        out_mem[{widx[4:0], 2'(b)}] <= PWDATA_I[8*b +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Poll every interval whether or not the image changed
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_r        <= fsb_pkg::HS_WAIT;
      tmr_r       <= 24'h000000;
      idx_r       <= 8'h00;
      cyc_cnt_r   <= 16'h0000;
      FB.ob_valid <= 1'b0;
      FB.ob_last  <= 1'b0;
      FB.ob_data  <= 8'h00;
      FB.ib_rd    <= 1'b0;
      FB.ib_idx   <= 7'h00;
    end else begin
      FB.ob_valid <= 1'b0;
      FB.ob_last  <= 1'b0;
      FB.ib_rd    <= 1'b0;
      case (st_r)
        fsb_pkg::HS_WAIT: begin
          tmr_r <= (tmr_r == 24'(POLL_CYC - 1)) ? 24'h000000 : tmr_r + 24'h000001;
          if (tmr_r == 24'(POLL_CYC - 1) && run_r) begin
            st_r  <= fsb_pkg::HS_OUT;
            idx_r <= 8'h00;
          end
        end
        fsb_pkg::HS_OUT: begin
          // Whole container every poll, marker byte first
          if (idx_r < olen_r) begin
            FB.ob_valid <= 1'b1;
            FB.ob_data  <= out_mem[idx_r[6:0]];
            FB.ob_last  <= idx_r == olen_r - 8'h01;
            idx_r       <= idx_r + 8'h01;
          end else begin
            st_r  <= fsb_pkg::HS_IN;
            idx_r <= 8'h00;
          end
        end
        fsb_pkg::HS_IN: begin
          // Only the configured size is read back
          if (idx_r < ilen_r) begin
            FB.ib_rd  <= 1'b1;
            FB.ib_idx <= idx_r[6:0];
            idx_r     <= idx_r + 8'h01;
          end else if (!FB.ib_rd) begin
            st_r      <= fsb_pkg::HS_WAIT;
            cyc_cnt_r <= cyc_cnt_r + 16'h0001;
          end
        end
        default: begin
          st_r <= fsb_pkg::HS_WAIT;
        end
      endcase
    end
  end

  // Capture answers; software compares the counter byte for freshness
  always_ff @(posedge CLK_SYS_I) begin
    cap_idx_r <= FB.ib_idx;
    if (FB.ib_valid) begin
      in_mem[cap_idx_r] <= FB.ib_data;
    end
  end

endmodule

/* File: logic/fsb_if.sv */
// Cyclic image exchange link between fieldbus master and bridge
`timescale 1ns/1ns
interface fsb_if;
  logic       ob_valid;  // Output image byte strobe
  logic [7:0] ob_data;   // Output image byte, index 0 first
  logic       ob_last;   // Marks last byte of the output image
  logic       ib_rd;     // Input image byte read request
  logic [6:0] ib_idx;    // Input image byte index
  logic [7:0] ib_data;   // Input image byte answer
  logic       ib_valid;  // Answer strobe, one cycle after request

  modport dev  (input ob_valid, ob_data, ob_last, ib_rd, ib_idx,
                output ib_data, ib_valid);
  modport host (output ob_valid, ob_data, ob_last, ib_rd, ib_idx,
                input ib_data, ib_valid);
endinterface

/* File: logic/fsb_pkg.sv */
// Shared constants and types for the fieldbus to serial image bridge
package fsb_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Image geometry
  localparam int IMG_MAX     = 128;  // Bytes per image, both directions
  localparam int IN_HDR      = 3;    // Status bytes ahead of rx payload
  localparam int OUT_HDR     = 5;    // Setting bytes ahead of tx payload
  localparam int IN_PAY_MAX  = 125;  // Rx payload room in input image

  // Output image byte positions (zero based)
  localparam int OB_CMD  = 0;  // Command marker
  localparam int OB_CTRL = 1;  // Control bits
  localparam int OB_LEN  = 2;  // Output payload length
  localparam int OB_TMO  = 3;  // Receive gap timeout
  localparam int OB_FIX  = 4;  // Fixed receive length

  // Input image byte positions (zero based)
  localparam int IB_STATE = 0;
  localparam int IB_LEN   = 1;
  localparam int IB_CNT   = 2;

  // Control byte fields
  localparam int DIAG_CLR_POS = 0;
  localparam int CNT_CLR_POS  = 1;

  // Transfer state byte encodings
  localparam logic [7:0] XS_IDLE = 8'h00;
  localparam logic [7:0] XS_SEND = 8'h01;
  localparam logic [7:0] XS_COPY = 8'h02;

  // Reset values
  localparam logic [7:0] CMD_RST = 8'h00;  // Marker assumed before first image
  localparam logic [7:0] LEN_RST = 8'h00;  // Output length after reset

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int TMO_UNIT_MS  = 1;   // Base timeout unit in ms
  localparam int TMO_UNIT_X10 = 10;  // Coarse unit multiplier
  localparam int MS_CYC_DEF   = CLK_HZ / 1000 * TMO_UNIT_MS;
  localparam int CHAR_US      = 1042;  // One character time, in us
  localparam int CHAR_CYC_DEF = CHAR_US * (CLK_HZ / 1_000_000);
  localparam int POLL_MS      = 2;     // Host polling interval in ms
  localparam int POLL_CYC_DEF = POLL_MS * (CLK_HZ / 1000);

  ////////////////////////////////////////////////////////////////////////
  // Host register map (byte addresses)
  localparam logic [11:0] RA_CTRL   = 12'h000;  // Run, image sizes
  localparam logic [11:0] RA_STAT   = 12'h004;  // Cycle count, busy
  localparam logic [11:0] RA_OUTIMG = 12'h100;  // Output image, 32 words
  localparam logic [11:0] RA_INIMG  = 12'h200;  // Input image, 32 words
  localparam int CTRL_RUN_POS  = 0;
  localparam int CTRL_OLEN_LSB = 8;
  localparam int CTRL_ILEN_LSB = 16;

  ////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [1:0] {DS_IDLE, DS_SEND, DS_COPY} fsb_dev_st_t;
  typedef enum logic [1:0] {HS_WAIT, HS_OUT, HS_IN} fsb_host_st_t;

  // Smaller of two byte counts
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

endpackage

/* File: test/fieldbus_serial_image_bridge_tb.sv */
// Bench joining the host poller and the bridge over the image link
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module fieldbus_serial_image_bridge_tb;
  localparam logic [7:0] MK [4] = '{8'h01, 8'h01, 8'h02, 8'h03};  // Markers per step
  localparam logic [7:0] CT [4] = '{8'h00, 8'h00, 8'h00, 8'h03};  // Control bytes
  localparam logic [7:0] LN [4] = '{8'h03, 8'h07, 8'hc8, 8'h00};  // Length bytes
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, txr = 0, rxv = 0, lst = 0, acc;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd;
  logic [7:0]  txd, rxd = 0, e, te, last = 0, ob [12], rxm [9];
  logic        prdy, perr, txv, dclr, er, fx = 0, t10 = 0;
  logic [7:0]  exq [$];  // Bytes the serial port should still see
  int          bad_count = 0, n_compared = 0, cyc = 0, nd = 0, len = 0, cnt = 0, n, k;
  fsb_if link ();
  fsb_dev #(.MS_CYC(10), .CHAR_CYC(20)) fsb_dev_inst (.CLK_SYS_I(clk), .RST_I(rst), .FB(link),
    .TX_DATA_O(txd), .TX_VALID_O(txv), .TX_READY_I(txr), .RX_DATA_I(rxd), .RX_VALID_I(rxv),
    .LISTEN_I(lst), .FIX_EN_I(fx), .TMO_10MS_I(t10), .DIAG_CLR_O(dclr));
  fsb_host #(.POLL_CYC(300)) fsb_host_inst (.CLK_SYS_I(clk), .RST_I(rst), .FB(link),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr));
  fsb_assertions fsb_assertions_inst (.CLK_SYS_I(clk), .RST_I(rst), .ob_valid(link.ob_valid),
    .ob_last(link.ob_last), .ib_rd(link.ib_rd), .ib_idx(link.ib_idx), .ib_data(link.ib_data),
    .ib_valid(link.ib_valid), .TX_VALID_O(txv), .TX_DATA_O(txd), .TX_READY_I(txr),
    .DIAG_CLR_O(dclr));
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Serial port with random stalls; every taken byte checked, cycle limit
  always @(posedge clk) begin
    txr <= 1'($urandom);
    if (dclr === 1'b1) nd++;
    if (txv === 1'b1 && txr) begin
      te = exq.size() ? exq.pop_front() : 8'hxx;  // Unexpected byte never matches
      `CHK("tx byte", te, txd)
    end
    if (++cyc == 20000) begin bad_count++; close_out; end
  end
  // APB transfer; waits for ready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    {rd, er} = {prd, perr};
    {psel, pen} <= 2'b0;
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Steps: new send, same marker, over-long length, counter and diag clear
  initial begin
    k = $urandom(32'h5d31);
    repeat (20) @(posedge clk);
    rst <= 0;
    apb(1, 12'h008, 0);
    `CHK("slverr", 1'b1, er)
    apb(1, 12'h000, 32'h000c0c01);  // Run, 12 byte images each way
    for (int s = 0; s < 4; s++) begin
      lst <= (s > 1);  // Listener for the last two steps
      {fx, t10} <= {s == 3, s == 2};  // Fixed length in step 3, 10 ms unit in step 2
      k = 1 + $urandom % 9;
      foreach (ob[i]) ob[i] = 8'($urandom);
      {ob[0], ob[1], ob[2], ob[3], ob[4]} = {MK[s], CT[s], LN[s], 8'(s), 8'(k)};
      // Marker word last, so a poll never sees a new marker with old payload
      for (int w = 2; w >= 0; w--)
        apb(1, 12'h100 + 12'(4 * w), {ob[4 * w + 3], ob[4 * w + 2], ob[4 * w + 1], ob[4 * w]});
      n = (ob[0] != last) ? ((LN[s] < 7) ? LN[s] : 7) : 0;
      for (int i = 0; i < n; i++) exq.push_back(ob[5 + i]);
      acc = (s > 1) || n > 0;  // Local master hears only after a send
      if (ob[0] != last && ob[1][1]) cnt = 0;
      last = ob[0];
      repeat (700) @(posedge clk);
      `CHK("tx left", 0, exq.size())
      for (int i = 0; i < k; i++) begin
        e = 8'($urandom);
        {rxd, rxv} <= {e, 1'b1};
        if (acc) rxm[i] = e;
        @(posedge clk);
      end
      rxv <= 0;
      if (acc) begin len = k; cnt = (cnt + 1) % 256; end
      repeat (760) @(posedge clk);
      for (int w = 0; w < 3; w++) begin
        apb(0, 12'h200 + 12'(4 * w), 0);
        for (int b = 0; b < 4; b++) begin
          n = 4 * w + b;
          e = (n == 0) ? 8'h00 : (n == 1) ? 8'(len) : (n == 2) ? 8'(cnt) : rxm[n - 3];
          if (n < 3 + len) `CHK("in byte", e, rd[8 * b +: 8])
        end
      end
    end
    `CHK("diag pulses", 1, nd)
    close_out;
  end
endmodule

/* File: test/fsb_assertions.sv */
// Checker for the image link and the serial transmit side
`timescale 1ns/1ns
module fsb_assertions (
  input wire logic       CLK_SYS_I,   // System clock
  input wire logic       RST_I,       // Synchronous reset
  input wire logic       ob_valid,    // Output image byte strobe
  input wire logic       ob_last,     // Last output image byte
  input wire logic       ib_rd,       // Input image read request
  input wire logic [6:0] ib_idx,      // Input image byte index
  input wire logic [7:0] ib_data,     // Input image answer
  input wire logic       ib_valid,    // Answer strobe
  input wire logic       TX_VALID_O,  // Serial byte offered
  input wire logic [7:0] TX_DATA_O,   // Serial byte
  input wire logic       TX_READY_I,  // Serial port takes byte
  input wire logic       DIAG_CLR_O   // Diagnostic clear pulse
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  AST_RD_ANSWER: assert property (ib_rd |=> ib_valid) else $error("read unanswered");
  AST_NO_STRAY: assert property (ib_valid |-> $past(ib_rd)) else $error("stray answer");
  AST_STATE_CODE: assert property (ib_rd && ib_idx == 7'h00 |=> ib_data <= 8'h02
    && (ib_data == 8'h01) == $past(TX_VALID_O)) else $error("bad state code");
  AST_IMG_HOLD: assert property (!ib_rd |=> $stable(ib_data)) else $error("image moved");
  AST_TX_HOLD: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("tx byte dropped");
  AST_TX_CAUSE: assert property ($rose(TX_VALID_O) |-> $past(ob_last, 3))
    else $error("tx without image");
  AST_LAST_BYTE: assert property (ob_last |-> ob_valid) else $error("last without byte");
  AST_DIAG_PULSE: assert property (DIAG_CLR_O |=> !DIAG_CLR_O) else $error("diag pulse long");
  // Main scenarios reached
  COV_TX: cover property (TX_VALID_O && TX_READY_I);
  COV_RD: cover property (ib_valid);
  COV_DIAG: cover property (DIAG_CLR_O);
endmodule
